// *** hdl/rtcs_top.v ***
// Real-time clock serial slave, event pin, supply switchover and trickle charge control
`timescale 1ns/1ps
`default_nettype none
`include "rtcs_map.vh"
module rtcs_top #(
    parameter SEC_CYC = `RTCS_SEC_CYC,
    parameter FAST_HALF_CYC = `RTCS_FAST_HALF_CYC,
    parameter CAL_STEP = `RTCS_CAL_STEP
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_scl,
    input wire i_sda_in,
    output reg o_sda_out,
    output reg o_sda_oe,
    input wire i_vcc_lt_backup_supply,
    input wire i_vcc_lt_vref,
    output reg o_on_backup,
    output reg o_irq_out,
    output reg o_irq_oe,
    output reg o_sw_key,
    output reg o_sw_second,
    output reg o_sw_diode,
    output reg o_sec_tick
);
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_AACK = 3'd2;
    localparam S_WRX = 3'd3;
    localparam S_WACK = 3'd4;
    localparam S_RTX = 3'd5;
    localparam S_RACK = 3'd6;

    function valid_ptr;
        input [7:0] p;
        begin
            valid_ptr = (p <= `RTCS_NORM_LAST) || (p >= `RTCS_SPEC_FIRST && p <= `RTCS_SPEC_LAST);
        end
    endfunction

    function [3:0] ptr_idx;
        input [7:0] p;
        begin
            ptr_idx = (p >= `RTCS_SPEC_FIRST) ? p[3:0] + 4'ha : p[3:0];
        end
    endfunction

    // Two-flop synchronisers: scl, sda, vcc<backup_supply, vcc<vref
    reg [3:0] sy1_q;
    reg [3:0] sy2_q;
    reg scl_q;
    reg sda_q;
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sy1_q <= 4'hf;
            sy2_q <= 4'hf;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            sy1_q <= {i_vcc_lt_vref, i_vcc_lt_backup_supply, i_sda_in, i_scl};
            sy2_q <= sy1_q;
            scl_q <= sy2_q[0];
            sda_q <= sy2_q[1];
        end
    end
    wire scl_s = sy2_q[0];
    wire sda_s = sy2_q[1];
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire start_ev = scl_s && scl_q && !sda_s && sda_q;
    wire stop_ev = scl_s && scl_q && sda_s && !sda_q;
    // Backup only when main is below both the backup level and the reference
    wire bk_d = sy2_q[2] && sy2_q[3];
    reg bk_q;
    wire bk_enter = bk_d && !bk_q;
    wire bk_leave = !bk_d && bk_q;

    // Register array and write FIFO
    reg [7:0] regs [0:15];
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    reg push_q;
    reg [15:0] push_data_q;
    // Queued writes are held while on backup; the slave refuses data bytes once the FIFO is full
    wire drain = !bk_q;

    rtcs_fifo #(.WIDTH(16), .DEPTH(8), .AW(3)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_in_valid(push_q),
        .o_in_ready(fifo_in_ready),
        .i_in_data(push_data_q),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(drain),
        .o_out_data(fifo_out_data)
    );

    integer k;
    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (k = 0; k < 16; k = k + 1)
            begin
                regs[k] <= `RTCS_OTHER_RST;
            end
            regs[`RTCS_IDX_CFG1] <= `RTCS_CFG1_RST;
            bk_q <= 1'b0;
        end
        else
        begin
            bk_q <= bk_d;
            if (bk_enter)
            begin
                // Test bits and charge switches reload; level and calibration stay
                regs[`RTCS_IDX_CFG1] <= regs[`RTCS_IDX_CFG1] & `RTCS_CFG1_KEEP;
                regs[`RTCS_IDX_TCH] <= regs[`RTCS_IDX_TCH] & `RTCS_TCH_KEEP;
                regs[`RTCS_IDX_CFG2] <= regs[`RTCS_IDX_CFG2] & `RTCS_CFG2_KEEP;
                regs[`RTCS_IDX_SFR] <= regs[`RTCS_IDX_SFR] & `RTCS_SFR_KEEP;
            end
            else if (fifo_out_valid && drain && valid_ptr(fifo_out_data[15:8]))
            begin
                regs[ptr_idx(fifo_out_data[15:8])] <= fifo_out_data[7:0];
            end
        end
    end

    // Serial slave; it never drives the clock line
    reg [2:0] st_q;
    reg [3:0] cnt_q;
    reg [7:0] sh_q;
    reg [7:0] tx_q;
    reg [7:0] ptr_q;
    reg rw_q;
    reg first_q;
    reg nack_q;
    wire [7:0] rd_byte = valid_ptr(ptr_q) ? regs[ptr_idx(ptr_q)] : 8'h00;

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_q <= S_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
            o_sda_oe <= 1'b0;
            o_sda_out <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= 16'h0000;
        end
        else
        begin
            push_q <= 1'b0;
            if (bk_q || stop_ev)
            begin
                st_q <= S_IDLE;
                o_sda_oe <= 1'b0;
            end
            else if (start_ev)
            begin
                st_q <= S_ADDR;
                cnt_q <= 4'h0;
                o_sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                if (st_q == S_ADDR || st_q == S_WRX)
                begin
                    sh_q <= {sh_q[6:0], sda_s};
                    cnt_q <= cnt_q + 4'h1;
                end
                else if (st_q == S_RTX)
                begin
                    cnt_q <= cnt_q + 4'h1;
                end
                else if (st_q == S_RACK)
                begin
                    nack_q <= sda_s;
                end
            end
            else if (scl_fall)
            begin
                case (st_q)
                    S_ADDR:
                    begin
                        if (cnt_q == 4'h8)
                        begin
                            // General call and foreign addresses fall back to idle
                            if (sh_q == `RTCS_ADDR_WR || sh_q == `RTCS_ADDR_RD)
                            begin
                                o_sda_oe <= 1'b1;
                                rw_q <= sh_q[0];
                                st_q <= S_AACK;
                            end
                            else
                            begin
                                st_q <= S_IDLE;
                            end
                        end
                    end
                    S_AACK:
                    begin
                        cnt_q <= 4'h0;
                        if (rw_q)
                        begin
                            tx_q <= rd_byte;
                            o_sda_oe <= ~rd_byte[7];
                            ptr_q <= ptr_q + 8'h01;
                            st_q <= S_RTX;
                        end
                        else
                        begin
                            o_sda_oe <= 1'b0;
                            first_q <= 1'b1;
                            st_q <= S_WRX;
                        end
                    end
                    S_WRX:
                    begin
                        if (cnt_q == 4'h8)
                        begin
                            if (first_q || fifo_in_ready)
                            begin
                                o_sda_oe <= 1'b1;
                                st_q <= S_WACK;
                            end
                            else
                            begin
                                st_q <= S_IDLE;
                            end
                        end
                    end
                    S_WACK:
                    begin
                        o_sda_oe <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= S_WRX;
                        first_q <= 1'b0;
                        if (first_q)
                        begin
                            ptr_q <= sh_q;
                        end
                        else
                        begin
                            push_q <= 1'b1;
                            push_data_q <= {ptr_q, sh_q};
                            ptr_q <= ptr_q + 8'h01;
                        end
                    end
                    S_RTX:
                    begin
                        if (cnt_q == 4'h8)
                        begin
                            o_sda_oe <= 1'b0;
                            st_q <= S_RACK;
                        end
                        else
                        begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            o_sda_oe <= ~tx_q[6];
                        end
                    end
                    S_RACK:
                    begin
                        cnt_q <= 4'h0;
                        if (nack_q)
                        begin
                            st_q <= S_IDLE;
                        end
                        else
                        begin
                            tx_q <= rd_byte;
                            o_sda_oe <= ~rd_byte[7];
                            ptr_q <= ptr_q + 8'h01;
                            st_q <= S_RTX;
                        end
                    end
                    default:
                    begin
                        st_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // Seconds with calibration; restarted on leaving backup
    wire [7:0] cfg1 = regs[`RTCS_IDX_CFG1];
    reg [31:0] sec_cnt_q;
    reg [9:0] cal_sec_q;
    // Seventeen bits: the full-rate half period of the fast output does not fit in sixteen
    reg [16:0] half_cnt_q;
    reg fast_q;
    wire cal_sign = cfg1[`RTCS_CAL_SIGN_BIT];
    wire [9:0] cal_lim = cal_sign ? `RTCS_CAL_POS_SEC : `RTCS_CAL_NEG_SEC;
    wire cal_now = (cal_sec_q == cal_lim - 10'h001);
    wire [31:0] cal_adj = cfg1[4:0] * CAL_STEP;
    wire [31:0] sec_len = !cal_now ? SEC_CYC : (cal_sign ? SEC_CYC - cal_adj : SEC_CYC + cal_adj);
    wire sec_end = (sec_cnt_q >= sec_len - 32'h1);
    wire slow_lvl = (sec_cnt_q < {1'b0, sec_len[31:1]});

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sec_cnt_q <= 32'h0;
            cal_sec_q <= 10'h000;
            half_cnt_q <= 17'h00000;
            fast_q <= 1'b0;
            o_sec_tick <= 1'b0;
        end
        else
        begin
            o_sec_tick <= 1'b0;
            if (bk_leave)
            begin
                sec_cnt_q <= 32'h0;
            end
            else if (sec_end)
            begin
                sec_cnt_q <= 32'h0;
                o_sec_tick <= 1'b1;
                cal_sec_q <= cal_now ? 10'h000 : cal_sec_q + 10'h001;
            end
            else
            begin
                sec_cnt_q <= sec_cnt_q + 32'h1;
            end
            if (half_cnt_q == FAST_HALF_CYC[16:0] - 17'h00001)
            begin
                half_cnt_q <= 17'h00000;
                fast_q <= ~fast_q;
            end
            else
            begin
                half_cnt_q <= half_cnt_q + 17'h00001;
            end
        end
    end

    // Event pin and charge switches
    wire fte = cfg1[`RTCS_FTE_BIT];
    wire rate = regs[`RTCS_IDX_SFR][`RTCS_RATE_BIT];
    wire irq_lvl = fte ? (rate ? slow_lvl : fast_q) : cfg1[`RTCS_OUT_BIT];
    wire [7:0] cfg2 = regs[`RTCS_IDX_CFG2];

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_irq_out <= 1'b0;
            o_irq_oe <= 1'b0;
            o_on_backup <= 1'b0;
            o_sw_key <= 1'b0;
            o_sw_second <= 1'b0;
            o_sw_diode <= 1'b0;
        end
        else
        begin
            o_irq_out <= 1'b0;
            o_irq_oe <= !bk_d && !irq_lvl;
            o_on_backup <= bk_d;
            // Open on the same edge that the backup bits reload, straight from the supply level
            o_sw_key <= !bk_d && (cfg2[3:0] == `RTCS_KEY_OPEN);
            o_sw_second <= !bk_d && regs[`RTCS_IDX_TCH][`RTCS_SECOND_SW_BIT];
            o_sw_diode <= !bk_d && cfg2[`RTCS_DIODE_BIT];
        end
    end
endmodule // rtcs_top
`default_nettype wire

// *** hdl/rtcs_map.vh ***
// Constants for the real-time clock serial slave and support logic
`ifndef RTCS_MAP_VH
`define RTCS_MAP_VH
// Clock rate and output rates
`define RTCS_CLK_HZ 100000000
`define RTCS_SLOW_HZ 1
`define RTCS_FAST_HZ 512
`define RTCS_SEC_CYC (`RTCS_CLK_HZ / `RTCS_SLOW_HZ)
`define RTCS_FAST_HALF_CYC (`RTCS_CLK_HZ / (2 * `RTCS_FAST_HZ))
`define RTCS_CAL_STEP 100
// Calibration intervals in seconds
`define RTCS_CAL_POS_SEC 10'h1e0
`define RTCS_CAL_NEG_SEC 10'h3c0
// Slave addresses
`define RTCS_ADDR_WR 8'hd0
`define RTCS_ADDR_RD 8'hd1
// Register indexes in the local array and valid bus pointer ranges
`define RTCS_IDX_CFG1 4'h7
`define RTCS_IDX_TCH 4'h8
`define RTCS_IDX_CFG2 4'h9
`define RTCS_IDX_SFR 4'hc
`define RTCS_NORM_LAST 8'h09
`define RTCS_SPEC_FIRST 8'h20
`define RTCS_SPEC_LAST 8'h22
// Field positions and the switch key value
`define RTCS_OUT_BIT 7
`define RTCS_FTE_BIT 6
`define RTCS_CAL_SIGN_BIT 5
`define RTCS_SECOND_SW_BIT 5
`define RTCS_DIODE_BIT 6
`define RTCS_RATE_BIT 0
`define RTCS_KEY_OPEN 4'h5
// Reset values and bits kept through a switch to backup
`define RTCS_CFG1_RST 8'h80
`define RTCS_OTHER_RST 8'h00
`define RTCS_CFG1_KEEP 8'hbf
`define RTCS_TCH_KEEP 8'hdf
`define RTCS_CFG2_KEEP 8'hb0
`define RTCS_SFR_KEEP 8'hfe
`endif

// *** hdl/rtcs_fifo.v ***
// Write-data FIFO between the serial slave and the register array
`timescale 1ns/1ps
`default_nettype none
module rtcs_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign o_in_ready = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_q];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always @(posedge i_clk)
    begin
        if (push)
        begin
            mem[wr_q] <= i_in_data;
        end
    end

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // rtcs_fifo
`default_nettype wire

// *** tb/rtcs_top_monitor.sv ***
// Concurrent checks on the serial slave, event pin and supply switchover ports
`timescale 1ns/1ps
`default_nettype none
module rtcs_top_monitor #(
    parameter SEC_CYC = 2000,
    parameter FAST_HALF_CYC = 20,
    parameter CAL_STEP = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda_in,
    input wire logic o_sda_out,
    input wire logic o_sda_oe,
    input wire logic i_vcc_lt_backup_supply,
    input wire logic i_vcc_lt_vref,
    input wire logic o_on_backup,
    input wire logic o_irq_out,
    input wire logic o_irq_oe,
    input wire logic o_sw_key,
    input wire logic o_sw_second,
    input wire logic o_sw_diode,
    input wire logic o_sec_tick
);
    default clocking mon_cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    AST_BACKUP_ENTRY: assert property ((i_vcc_lt_backup_supply && i_vcc_lt_vref) [*5] |-> o_on_backup)
        else $error("backup supply not selected with main below both levels");
    AST_MAIN_BACKUP_SUPPLY: assert property ((!i_vcc_lt_backup_supply) [*5] |-> !o_on_backup)
        else $error("backup supply kept with main above backup level");
    AST_MAIN_VREF: assert property ((!i_vcc_lt_vref) [*5] |-> !o_on_backup)
        else $error("backup supply kept with main above reference");
    AST_IRQ_RELEASED: assert property ($past(o_on_backup) && o_on_backup |-> !o_irq_oe)
        else $error("event pin pulled while on backup supply");
    AST_SW_OPEN: assert property ($past(o_on_backup) && o_on_backup |-> !(o_sw_key || o_sw_second || o_sw_diode))
        else $error("charge switch closed while on backup supply");
    AST_BUS_RELEASED: assert property ($past(o_on_backup) && o_on_backup |-> !o_sda_oe)
        else $error("data line pulled while on backup supply");
    AST_SDA_STEADY: assert property (i_scl && $past(i_scl) && !o_on_backup |-> $stable(o_sda_oe))
        else $error("data line changed by slave while clock high");
    AST_OPEN_DRAIN: assert property (o_sda_oe || o_irq_oe |-> !o_sda_out && !o_irq_out)
        else $error("open-drain pin driven high");
    AST_TICK_PULSE: assert property ($rose(o_sec_tick) |=> (!o_sec_tick) [*8])
        else $error("second tick longer than one cycle or too close");
endmodule // rtcs_top_monitor
bind rtcs_top rtcs_top_monitor #(.SEC_CYC(SEC_CYC), .FAST_HALF_CYC(FAST_HALF_CYC), .CAL_STEP(CAL_STEP)) u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .i_vcc_lt_backup_supply(i_vcc_lt_backup_supply), .i_vcc_lt_vref(i_vcc_lt_vref),
    .o_on_backup(o_on_backup), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe), .o_sw_key(o_sw_key),
    .o_sw_second(o_sw_second), .o_sw_diode(o_sw_diode), .o_sec_tick(o_sec_tick));
`default_nettype wire

// *** tb/rtcs_bus_master.sv ***
// Two-wire bus master model driving the serial clock and the pulled-up data line
`timescale 1ns/1ps
`default_nettype none
module rtcs_bus_master (
    input wire logic i_sda_oe,
    output logic o_scl,
    output logic o_sda
);
    logic sda_drv_q;
    // Pull-up: the line is low whenever either side pulls it
    assign o_sda = sda_drv_q & ~i_sda_oe;
    initial
    begin
        o_scl = 1'b1;
        sda_drv_q = 1'b1;
    end
    // Data moves 10 ns after the clock falls so no start or stop is faked
    // One bit takes 80 ns, scaled down like the second and event timings of the bench
    task automatic bit_io(input logic b, output logic s);
        o_scl = 1'b0;
        #10 sda_drv_q = b;
        #40 o_scl = 1'b1;
        #20 s = o_sda;
        #10;
    endtask
    task automatic start_c();
        o_scl = 1'b0;
        #10 sda_drv_q = 1'b1;
        #40 o_scl = 1'b1;
        #20 sda_drv_q = 1'b0;
        #10;
    endtask
    task automatic stop_c();
        o_scl = 1'b0;
        #10 sda_drv_q = 1'b0;
        #40 o_scl = 1'b1;
        #20 sda_drv_q = 1'b1;
        #10;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(output logic [7:0] b, input logic last);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, b[i]);
        bit_io(last, s);
    endtask
endmodule // rtcs_bus_master
`default_nettype wire

// *** tb/test_rtcs_top.sv ***
// Testbench for the serial slave, event pin, switchover and trickle charge control
`timescale 1ns/1ps
`default_nettype none
module test_rtcs_top;
    logic i_clk, i_rst_n, scl, sda, vlt_back, vlt_ref;
    logic sda_out, sda_oe, on_backup, irq_out, irq_oe, sw_key, sw_second, sw_diode, sec_tick;
    logic [7:0] rd;
    logic ack;
    logic [7:0] bad_addr [0:2] = '{8'ha0, 8'h00, 8'hd2};
    int n_errors = 0;
    int samples_checked = 0;
    rtcs_top #(.SEC_CYC(2000), .FAST_HALF_CYC(20), .CAL_STEP(1)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda_in(sda), .o_sda_out(sda_out),
        .o_sda_oe(sda_oe), .i_vcc_lt_backup_supply(vlt_back), .i_vcc_lt_vref(vlt_ref), .o_on_backup(on_backup),
        .o_irq_out(irq_out), .o_irq_oe(irq_oe), .o_sw_key(sw_key), .o_sw_second(sw_second),
        .o_sw_diode(sw_diode), .o_sec_tick(sec_tick));
    rtcs_bus_master u_mst (.i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d0, input logic [7:0] d1, input int n);
        u_mst.start_c();
        u_mst.send_byte(8'hd0, ack);
        chk("write address ack", 1'b1, ack);
        u_mst.send_byte(ptr, ack);
        chk("pointer ack", 1'b1, ack);
        u_mst.send_byte(d0, ack);
        chk("data ack", 1'b1, ack);
        if (n > 1)
            u_mst.send_byte(d1, ack);
        u_mst.stop_c();
        repeat (6) @(negedge i_clk);
    endtask
    task automatic rd_reg(input logic [7:0] ptr, input logic [7:0] exp);
        u_mst.start_c();
        u_mst.send_byte(8'hd0, ack);
        u_mst.send_byte(ptr, ack);
        u_mst.start_c();
        u_mst.send_byte(8'hd1, ack);
        chk("read address ack", 1'b1, ack);
        u_mst.recv_byte(rd, 1'b1);
        u_mst.stop_c();
        chk("read data", exp, rd);
        repeat (6) @(negedge i_clk);
    endtask
    // Counts cycles between two successive changes of the event pin
    task automatic irq_gap(input int exp);
        logic prev;
        int n;
        for (int k = 0; k < 2; k++)
        begin
            prev = irq_oe;
            n = 0;
            while (irq_oe === prev)
            begin
                @(negedge i_clk);
                n++;
                if (n > 3000)
                begin
                    n_errors++;
                    $display("ERROR event pin toggle expected change seen none");
                    complete_run();
                end
            end
        end
        chk("event pin half period", exp, n);
    endtask
    // Counts cycles from one second tick to the next
    task automatic tick_gap(input int exp);
        int n;
        n = 0;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do
            begin
                @(negedge i_clk);
                n++;
                if (n > 3000)
                begin
                    n_errors++;
                    $display("ERROR second tick expected pulse seen none");
                    complete_run();
                end
            end
            while (sec_tick !== 1'b1);
        end
        chk("second tick period", exp, n);
    endtask
    initial
    begin
        #900us;
        n_errors++;
        $display("ERROR run length expected end seen timeout");
        complete_run();
    end
    initial
    begin
        i_rst_n = 1'b0;
        vlt_back = 1'b0;
        vlt_ref = 1'b0;
        repeat (16) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (8) @(negedge i_clk);
        chk("event pin after power-on", 1'b0, irq_oe);
        chk("switches after power-on", 3'b000, {sw_key, sw_second, sw_diode});
        chk("open-drain levels", 2'b00, {sda_out, irq_out});
        rd_reg(8'h07, 8'h80);
        wr_reg(8'h07, 8'h00, 8'h00, 1);
        chk("static low level", 1'b1, irq_oe);
        wr_reg(8'h07, 8'h43, 8'h00, 1);
        irq_gap(20);
        wr_reg(8'h22, 8'h01, 8'h00, 1);
        irq_gap(1000);
        tick_gap(2000);
        wr_reg(8'h08, 8'h20, 8'h45, 2);
        chk("charge switches", 3'b111, {sw_key, sw_second, sw_diode});
        wr_reg(8'h09, 8'h44, 8'h00, 1);
        chk("charge switches wrong key", 3'b011, {sw_key, sw_second, sw_diode});
        rd_reg(8'h08, 8'h20);
        for (int i = 0; i < 3; i++)
        begin
            u_mst.start_c();
            u_mst.send_byte(bad_addr[i], ack);
            u_mst.stop_c();
            chk("foreign address ack", 1'b0, ack);
        end
        vlt_back = 1'b1;
        repeat (10) @(negedge i_clk);
        chk("one comparator only", 1'b0, on_backup);
        vlt_ref = 1'b1;
        repeat (10) @(negedge i_clk);
        chk("backup selected", 1'b1, on_backup);
        chk("pins on backup", 4'h0, {irq_oe, sw_key, sw_second, sw_diode});
        vlt_back = 1'b0;
        repeat (10) @(negedge i_clk);
        chk("main supply back", 1'b0, on_backup);
        vlt_ref = 1'b0;
        repeat (6000) @(negedge i_clk);
        chk("static level kept", 1'b1, irq_oe);
        rd_reg(8'h07, 8'h03);
        rd_reg(8'h22, 8'h00);
        rd_reg(8'h09, 8'h00);
        chk("switches after backup", 3'b000, {sw_key, sw_second, sw_diode});
        // A byte cut short by a stop must leave the pointed register alone
        u_mst.start_c();
        u_mst.send_byte(8'hd0, ack);
        u_mst.send_byte(8'h07, ack);
        for (int i = 0; i < 4; i++)
            u_mst.bit_io(1'b1, ack);
        u_mst.stop_c();
        repeat (6) @(negedge i_clk);
        rd_reg(8'h07, 8'h03);
        complete_run();
    end
endmodule // test_rtcs_top
`default_nettype wire
